// [rtl/fbc_pkg.sv]
// package of constants for the flash bank command controller
package fbc_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    // host register offsets (word index)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h1;
    localparam logic [3:0] REG_WDATA = 4'h2;
    localparam logic [3:0] REG_RDATA = 4'h3;
    localparam logic [3:0] REG_STAT = 4'h4;
    // control register command codes
    localparam logic [3:0] OP_READ = 4'h1;
    localparam logic [3:0] OP_RESET = 4'h2;
    localparam logic [3:0] OP_PROGRAM = 4'h3;
    localparam logic [3:0] OP_AUTOSEL = 4'h4;
    localparam logic [3:0] OP_BYP_ENTER = 4'h5;
    localparam logic [3:0] OP_BYP_PROG = 4'h6;
    localparam logic [3:0] OP_BYP_EXIT = 4'h7;
    localparam logic [3:0] OP_SEC_ENTER = 4'h8;
    localparam logic [3:0] OP_SEC_EXIT = 4'h9;
    localparam logic [3:0] OP_HW_RESET = 4'hA;
    // control register fields
    localparam int CTRL_ACCEL_BIT = 4;
    localparam int CTRL_BYTE_BIT = 5;
    // flash command addresses and data
    localparam logic [ADDR_W-1:0] UNLOCK_A1 = 20'h00555;
    localparam logic [ADDR_W-1:0] UNLOCK_A2 = 20'h002AA;
    localparam logic [7:0] UNLOCK_D1 = 8'hAA;
    localparam logic [7:0] UNLOCK_D2 = 8'h55;
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [7:0] CMD_AUTOSEL = 8'h90;
    localparam logic [7:0] CMD_PROGRAM = 8'hA0;
    localparam logic [7:0] CMD_BYPASS = 8'h20;
    localparam logic [7:0] CMD_BYP_RST1 = 8'h90;
    localparam logic [7:0] CMD_BYP_RST2 = 8'h00;
    localparam logic [7:0] CMD_SEC_ENTER = 8'h88;
    localparam logic [7:0] CMD_SEC_EXIT = 8'h90;
    localparam logic [7:0] CMD_SEC_EXIT2 = 8'h00;
    // bus timing in ns and cycles at 100 MHz
    localparam int CLK_NS = 10;
    localparam int STROBE_NS = 40;
    localparam int SETUP_NS = 20;
    localparam int ACCESS_NS = 70;
    localparam int HWRST_NS = 500;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int HWRST_CYC = (HWRST_NS + CLK_NS - 1) / CLK_NS;
endpackage

// [rtl/fbc_bus_cycle.sv]
// one flash bus cycle: write or read with strobe timing
module fbc_bus_cycle #(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // request
    input wire logic start_i,
    input wire logic write_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] data_i,
    output logic done_o,
    output logic [DATA_W-1:0] rdata_o,
    // flash pins
    output logic [ADDR_W-1:0] fl_addr_o,
    output logic [DATA_W-1:0] fl_dq_o,
    output logic fl_dq_oe_n_o,
    input wire logic [DATA_W-1:0] fl_dq_i,
    output logic fl_ce_n_o,
    output logic fl_we_n_o,
    output logic fl_oe_n_o
);
    typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD} fbc_cy_e;
    fbc_cy_e st_q;
    logic [7:0] cnt_q;
    logic wr_q;
    logic [DATA_W-1:0] s1_q, s2_q;
    logic cnt_zero;
    assign cnt_zero = (cnt_q == 8'h00);
    assign done_o = (st_q == CY_HOLD);

    // pin synchroniser for read data
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= fl_dq_i;
            s2_q <= s1_q;
        end
    end

    // ce falls in the same cycle the address is driven; we falls later so address is latched on its edge
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q <= CY_IDLE;
            cnt_q <= 8'h00;
            wr_q <= 1'b0;
            fl_addr_o <= '0;
            fl_dq_o <= '0;
            fl_dq_oe_n_o <= 1'b1;
            fl_ce_n_o <= 1'b1;
            fl_we_n_o <= 1'b1;
            fl_oe_n_o <= 1'b1;
            rdata_o <= '0;
        end else begin
            case (st_q)
                CY_IDLE: begin
                    if (start_i) begin
                        wr_q <= write_i;
                        fl_addr_o <= addr_i;
                        fl_dq_o <= data_i;
                        fl_dq_oe_n_o <= ~write_i;
                        fl_ce_n_o <= 1'b0;
                        cnt_q <= 8'(fbc_pkg::SETUP_CYC);
                        st_q <= CY_SETUP;
                    end
                end
                CY_SETUP: begin
                    if (cnt_zero) begin
                        fl_we_n_o <= ~wr_q;
                        fl_oe_n_o <= wr_q;
                        cnt_q <= wr_q ? 8'(fbc_pkg::STROBE_CYC) : 8'(fbc_pkg::ACCESS_CYC + 2);
                        st_q <= CY_STROBE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                CY_STROBE: begin
                    if (cnt_zero) begin
                        fl_we_n_o <= 1'b1;
                        fl_oe_n_o <= 1'b1;
                        rdata_o <= s2_q;
                        st_q <= CY_HOLD;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                CY_HOLD: begin
                    fl_ce_n_o <= 1'b1; // data held until after we rose first
                    fl_dq_oe_n_o <= 1'b1;
                    st_q <= CY_IDLE;
                end
                default: st_q <= CY_IDLE;
            endcase
        end
    end
endmodule

// [rtl/fbc_top.sv]
// host controller that issues flash command sequences over the flash pins
//
// Design decisions made here: the placing of the registers and strobed register access.
module fbc_top (
    // clock and reset
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    // register port
    input wire logic [3:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    // flash pins
    output logic [19:0] FL_ADDR_O,
    output logic [15:0] FL_DQ_O,
    output logic FL_DQ_OE_N_O,
    input wire logic [15:0] FL_DQ_I,
    output logic FL_CE_N_O,
    output logic FL_WE_N_O,
    output logic FL_OE_N_O,
    output logic FL_HW_RESET_N_O,
    output logic FL_BYTE_WIDTH_SELECT_N_O,
    output logic FL_ACCEL_HV_O,
    input wire logic FL_READY_BUSY_N_I
);
    localparam int AW = fbc_pkg::ADDR_W;
    localparam int DW = fbc_pkg::DATA_W;
    typedef enum logic [2:0] {S_IDLE, S_CYCLE, S_WAIT, S_HWRST, S_POLL} fbc_state_e;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    fbc_state_e st_q;
    logic [3:0] op_q;
    logic [2:0] step_q;
    logic [AW-1:0] tgt_addr_q;
    logic [DW-1:0] wdata_q;
    logic [DW-1:0] rdata_q;
    logic accel_q, byte_q, bypass_q, secure_q, err_q;
    logic [15:0] cnt_q;
    logic rb1_q, rb2_q;
    logic [31:0] rdata_out_q;
    logic start_q;
    // bus cycle engine
    logic cy_done;
    logic [DW-1:0] cy_rdata;
    logic cy_write;
    logic [AW-1:0] cy_addr;
    logic [DW-1:0] cy_data;
    logic [2:0] last_step;
    logic busy;

    ////////////////////////////////////////////////////////////////////////////
    // register decode
    wire wr_ctrl = WR_I && (ADDR_I == fbc_pkg::REG_CTRL);
    wire wr_addr = WR_I && (ADDR_I == fbc_pkg::REG_ADDR);
    wire wr_wdata = WR_I && (ADDR_I == fbc_pkg::REG_WDATA);
    wire [3:0] new_op = WDATA_I[3:0];
    assign busy = (st_q != S_IDLE);
    wire [31:0] stat_word = {27'h0, ~rb2_q, secure_q, bypass_q, err_q, busy};
    wire [31:0] rd_mux = (ADDR_I == fbc_pkg::REG_CTRL) ? {26'h0, byte_q, accel_q, op_q} :
                         (ADDR_I == fbc_pkg::REG_ADDR) ? {12'h0, tgt_addr_q} :
                         (ADDR_I == fbc_pkg::REG_WDATA) ? {16'h0, wdata_q} :
                         (ADDR_I == fbc_pkg::REG_RDATA) ? {16'h0, rdata_q} :
                         (ADDR_I == fbc_pkg::REG_STAT) ? stat_word : 32'h0000_0000;
    assign RDATA_O = rdata_out_q;
    assign FL_ACCEL_HV_O = accel_q;
    assign FL_BYTE_WIDTH_SELECT_N_O = ~byte_q;

    ////////////////////////////////////////////////////////////////////////////
    // sequence tables: unlocked commands send unlocks first, then command, then target; direct commands skip the unlocks
    wire [AW-1:0] tgt_a = tgt_addr_q;
    wire [7:0] wd8 = wdata_q[7:0];
    wire is_unlock1 = (step_q == 3'd0);
    wire is_unlock2 = (step_q == 3'd1);
    wire direct_op = (op_q == fbc_pkg::OP_READ) || (op_q == fbc_pkg::OP_RESET)
                   || (op_q == fbc_pkg::OP_BYP_PROG) || (op_q == fbc_pkg::OP_BYP_EXIT);
    // unlocked sequences: step 0/1 unlock, step 2 command, step 3 extra
    assign cy_write = (op_q != fbc_pkg::OP_READ);
    always_comb begin
        cy_addr = fbc_pkg::UNLOCK_A1;
        cy_data = {8'h00, fbc_pkg::UNLOCK_D1};
        last_step = 3'd2;
        if (direct_op) begin
            case (op_q)
                fbc_pkg::OP_READ: begin
                    cy_addr = tgt_a;
                    last_step = 3'd0;
                end
                fbc_pkg::OP_RESET: begin
                    cy_addr = tgt_a;
                    cy_data = {8'h00, fbc_pkg::CMD_RESET};
                    last_step = 3'd0;
                end
                fbc_pkg::OP_BYP_PROG: begin
                    cy_addr = (step_q == 3'd0) ? tgt_a : tgt_a;
                    cy_data = (step_q == 3'd0) ? {8'h00, fbc_pkg::CMD_PROGRAM} : wdata_q;
                    last_step = 3'd1;
                end
                default: begin
                    cy_addr = tgt_a;
                    cy_data = (step_q == 3'd0) ? {8'h00, fbc_pkg::CMD_BYP_RST1}
                                               : {8'h00, fbc_pkg::CMD_BYP_RST2};
                    last_step = 3'd1;
                end
            endcase
        end else if (is_unlock1) begin
            cy_addr = fbc_pkg::UNLOCK_A1;
            cy_data = {8'h00, fbc_pkg::UNLOCK_D1};
        end else if (is_unlock2) begin
            cy_addr = fbc_pkg::UNLOCK_A2;
            cy_data = {8'h00, fbc_pkg::UNLOCK_D2};
        end else begin
            case (op_q)
                fbc_pkg::OP_PROGRAM: begin
                    cy_addr = (step_q == 3'd2) ? fbc_pkg::UNLOCK_A1 : tgt_a;
                    cy_data = (step_q == 3'd2) ? {8'h00, fbc_pkg::CMD_PROGRAM} : wdata_q;
                    last_step = 3'd3;
                end
                fbc_pkg::OP_AUTOSEL: begin
                    cy_addr = tgt_a; // bank address carried in target
                    cy_data = {8'h00, fbc_pkg::CMD_AUTOSEL};
                end
                fbc_pkg::OP_BYP_ENTER: begin
                    cy_data = {8'h00, fbc_pkg::CMD_BYPASS};
                end
                fbc_pkg::OP_SEC_ENTER: begin
                    cy_data = {8'h00, fbc_pkg::CMD_SEC_ENTER};
                end
                fbc_pkg::OP_SEC_EXIT: begin
                    cy_data = (step_q == 3'd2) ? {8'h00, fbc_pkg::CMD_SEC_EXIT}
                                               : {8'h00, fbc_pkg::CMD_SEC_EXIT2};
                    last_step = 3'd3;
                end
                default: begin
                    cy_data = {8'h00, fbc_pkg::CMD_RESET};
                end
            endcase
        end
    end
    wire is_prog = (op_q == fbc_pkg::OP_PROGRAM) || (op_q == fbc_pkg::OP_BYP_PROG);
    wire poll_done = (cy_rdata[7] == wd8[7]); // completion poll bit matches data
    wire poll_limit = cy_rdata[5]; // time limit flag

    ////////////////////////////////////////////////////////////////////////////
    // ready/busy pin synchroniser
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rb1_q <= 1'b1;
            rb2_q <= 1'b1;
        end else begin
            rb1_q <= FL_READY_BUSY_N_I;
            rb2_q <= rb1_q;
        end
    end

    // register port read data, one cycle after the strobe
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rdata_out_q <= 32'h0000_0000;
        end else begin
            rdata_out_q <= RD_I ? rd_mux : 32'h0000_0000;
        end
    end

    // configuration registers
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            tgt_addr_q <= '0;
            wdata_q <= '0;
            accel_q <= 1'b0;
            byte_q <= 1'b0;
        end else begin
            if (wr_addr) tgt_addr_q <= WDATA_I[AW-1:0];
            if (wr_wdata) wdata_q <= WDATA_I[DW-1:0];
            if (wr_ctrl) begin
                accel_q <= WDATA_I[fbc_pkg::CTRL_ACCEL_BIT];
                byte_q <= WDATA_I[fbc_pkg::CTRL_BYTE_BIT];
            end
        end
    end

    // sequencer: one flash cycle per step; commands refused while busy
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st_q <= S_IDLE;
            op_q <= 4'h0;
            step_q <= 3'd0;
            start_q <= 1'b0;
            cnt_q <= 16'h0000;
            bypass_q <= 1'b0;
            secure_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= '0;
            FL_HW_RESET_N_O <= 1'b1;
        end else begin
            start_q <= 1'b0;
            case (st_q)
                S_IDLE: begin
                    if (wr_ctrl && new_op == fbc_pkg::OP_HW_RESET) begin
                        FL_HW_RESET_N_O <= 1'b0; // abort
                        cnt_q <= 16'(fbc_pkg::HWRST_CYC);
                        op_q <= new_op;
                        st_q <= S_HWRST;
                    end else if (wr_ctrl && new_op >= fbc_pkg::OP_READ && new_op <= fbc_pkg::OP_SEC_EXIT) begin
                        op_q <= new_op;
                        step_q <= 3'd0;
                        err_q <= 1'b0;
                        start_q <= 1'b1;
                        st_q <= S_CYCLE;
                    end
                end
                S_CYCLE: begin
                    if (cy_done) begin
                        if (step_q != last_step) begin
                            step_q <= step_q + 3'd1;
                            start_q <= 1'b1;
                        end else if (is_prog) begin
                            st_q <= S_POLL; // no command issued while programming
                            start_q <= 1'b1;
                            op_q <= fbc_pkg::OP_READ;
                            step_q <= 3'd0;
                        end else begin
                            if (op_q == fbc_pkg::OP_READ) rdata_q <= cy_rdata;
                            if (op_q == fbc_pkg::OP_BYP_ENTER) bypass_q <= 1'b1;
                            if (op_q == fbc_pkg::OP_BYP_EXIT) bypass_q <= 1'b0;
                            if (op_q == fbc_pkg::OP_SEC_ENTER) secure_q <= 1'b1;
                            if (op_q == fbc_pkg::OP_SEC_EXIT) secure_q <= 1'b0;
                            st_q <= S_IDLE;
                        end
                    end
                end
                S_POLL: begin
                    if (cy_done) begin
                        rdata_q <= cy_rdata;
                        if (poll_done) begin
                            st_q <= S_IDLE;
                        end else if (poll_limit) begin
                            err_q <= 1'b1; // host must write reset next
                            st_q <= S_IDLE;
                        end else begin
                            start_q <= 1'b1;
                        end
                    end
                end
                S_HWRST: begin
                    if (cnt_q == 16'h0000) begin
                        FL_HW_RESET_N_O <= 1'b1;
                        bypass_q <= 1'b0;
                        secure_q <= 1'b0;
                        st_q <= S_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flash bus cycle engine
    fbc_bus_cycle #(.ADDR_W(AW), .DATA_W(DW)) u_cycle (
        .clk_i(CLK_I),
        .arst_n_i(ARST_N_I),
        .start_i(start_q),
        .write_i(cy_write),
        .addr_i(cy_addr),
        .data_i(cy_data),
        .done_o(cy_done),
        .rdata_o(cy_rdata),
        .fl_addr_o(FL_ADDR_O),
        .fl_dq_o(FL_DQ_O),
        .fl_dq_oe_n_o(FL_DQ_OE_N_O),
        .fl_dq_i(FL_DQ_I),
        .fl_ce_n_o(FL_CE_N_O),
        .fl_we_n_o(FL_WE_N_O),
        .fl_oe_n_o(FL_OE_N_O)
    );
endmodule

// [verif/fbc_flash_model.sv]
// behavioural model of the dual-bank flash at its pins
module fbc_flash_model #(
    parameter logic [15:0] MAKER_CODE = 16'h00A5, // arbitrary value
    parameter logic [15:0] DEV_CODE = 16'h005A, // arbitrary value
    parameter logic [15:0] SEC_WORD = 16'hC3C3,
    parameter int BUSY_NS = 300
) (
    // flash pins
    input wire logic ce_n_i,
    input wire logic we_n_i,
    input wire logic oe_n_i,
    input wire logic hw_reset_n_i,
    input wire logic accel_i,
    input wire logic [19:0] addr_i,
    input wire logic [15:0] dq_i,
    output logic [15:0] dq_o = 16'h0000,
    output logic ready_busy_n_o
);
    logic [15:0] mem [int];
    logic [19:0] a_q;
    logic [15:0] pd = 16'h0000;
    logic act = 1'b0, busy = 1'b0, asel = 1'b0, byp = 1'b0, sec = 1'b0;
    int st = 0;
    int perr = 0;
    assign ready_busy_n_o = !busy;
    // address at the later falling strobe
    always @(negedge we_n_i or negedge ce_n_i) begin
        a_q = addr_i;
        act = !we_n_i && !ce_n_i;
    end
    // command decode at the first rising strobe, ignored while busy
    always @(posedge we_n_i or posedge ce_n_i) begin
        if (act && !busy) begin
            case (st)
                0: begin
                    st = (dq_i[7:0] == 8'hAA && a_q == 20'h00555) ? 1 : 0;
                    if (byp || accel_i) st = (dq_i[7:0] == 8'hA0) ? 3 : (dq_i[7:0] == 8'h90) ? 4 : st;
                    asel = asel && dq_i[7:0] != 8'hF0;
                    perr += (st == 0 && dq_i[7:0] != 8'hF0) ? 1 : 0;
                end
                1: st = (dq_i[7:0] == 8'h55 && a_q == 20'h002AA) ? 2 : 0;
                2: begin
                    st = (dq_i[7:0] == 8'hA0) ? 3 : (dq_i[7:0] == 8'h90 && sec) ? 5 : 0;
                    asel = asel || (dq_i[7:0] == 8'h90 && !sec);
                    byp = byp || dq_i[7:0] == 8'h20;
                    sec = sec || dq_i[7:0] == 8'h88;
                end
                3: begin
                    pd = dq_i;
                    mem[a_q] = (mem.exists(a_q) ? mem[a_q] : 16'hFFFF) & dq_i;
                    busy = 1'b1;
                    st = 0;
                end
                default: begin
                    byp = byp && !(st == 4 && dq_i[7:0] == 8'h00);
                    sec = sec && !(st == 5 && dq_i[7:0] == 8'h00);
                    st = 0;
                end
            endcase
        end
        act = 1'b0;
    end
    // internal routine time
    always @(posedge busy) begin
        #(BUSY_NS);
        busy = 1'b0;
    end
    // hardware reset aborts everything and leaves the secured region
    always @(negedge hw_reset_n_i) begin
        {busy, asel, byp, sec} = 4'h0;
        st = 0;
    end
    // read data from the enable fall, inverse once released
    always @(negedge oe_n_i) begin
        #1;
        dq_o = busy ? {8'h00, ~pd[7], 7'h00} : sec ? SEC_WORD : !asel ? (mem.exists(addr_i) ? mem[addr_i] : 16'hFFFF)
            : addr_i[7:0] == 8'h00 ? MAKER_CODE : addr_i[7:0] == 8'h01 ? DEV_CODE : 16'h0001;
    end
    always @(posedge oe_n_i) dq_o = ~dq_o;
endmodule

// [verif/fbc_chk_sva.sv]
// assertions on the controller pins and register port
module fbc_chk (
    // clock, reset and register port
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [31:0] RDATA_O,
    // flash pins
    input wire logic [19:0] FL_ADDR_O,
    input wire logic [15:0] FL_DQ_O,
    input wire logic FL_DQ_OE_N_O,
    input wire logic FL_CE_N_O,
    input wire logic FL_WE_N_O,
    input wire logic FL_OE_N_O,
    input wire logic FL_HW_RESET_N_O,
    input wire logic FL_BYTE_WIDTH_SELECT_N_O,
    input wire logic FL_ACCEL_HV_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!ARST_N_I);
    logic [7:0] low_cnt_q;
    logic ctrl_wr;
    assign ctrl_wr = WR_I && ADDR_I == fbc_pkg::REG_CTRL;
    // cycles spent with the hardware reset line low
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            low_cnt_q <= 8'h00;
        end else begin
            low_cnt_q <= FL_HW_RESET_N_O ? 8'h00 : low_cnt_q + 8'h01;
        end
    end
    sequence s_we_pulse;
        (!FL_WE_N_O)[*5] ##1 FL_WE_N_O;
    endsequence
    sequence s_ce_release;
        !FL_CE_N_O ##1 FL_CE_N_O;
    endsequence
    AST_WE_PULSE: assert property ($fell(FL_WE_N_O) |-> s_we_pulse)
        else $error("write strobe width wrong");
    AST_CE_SETUP: assert property ($fell(FL_WE_N_O) |-> $past(!FL_CE_N_O, 2) && $stable(FL_ADDR_O))
        else $error("chip select not ahead of write strobe");
    AST_CE_AFTER: assert property ($rose(FL_WE_N_O) |-> s_ce_release)
        else $error("chip select not released after write");
    AST_WR_HOLD: assert property (!FL_WE_N_O && !$past(FL_WE_N_O) |-> $stable(FL_ADDR_O) && $stable(FL_DQ_O))
        else $error("address or data moved under write strobe");
    AST_WR_DRIVE: assert property (!FL_WE_N_O |-> !FL_DQ_OE_N_O && !FL_CE_N_O && FL_OE_N_O)
        else $error("data not driven during write");
    AST_READ_PULSE: assert property ($fell(FL_OE_N_O) |-> (!FL_OE_N_O && !FL_CE_N_O && FL_DQ_OE_N_O)[*7])
        else $error("read strobe too short or bus contended");
    AST_RDATA_IDLE: assert property (!$past(RD_I) |-> RDATA_O == 32'h0000_0000)
        else $error("read data outside its cycle");
    AST_BYTE_PIN: assert property (ctrl_wr |=> FL_BYTE_WIDTH_SELECT_N_O == !$past(WDATA_I[5]))
        else $error("byte select pin wrong");
    AST_ACCEL_PIN: assert property (ctrl_wr |=> FL_ACCEL_HV_O == $past(WDATA_I[4]))
        else $error("accelerate pin wrong");
    AST_HWRST_LEN: assert property ($rose(FL_HW_RESET_N_O) |-> low_cnt_q >= fbc_pkg::HWRST_CYC)
        else $error("hardware reset pulse too short");
endmodule
bind fbc_top fbc_chk i_chk (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
    .RD_I(RD_I), .RDATA_O(RDATA_O), .FL_ADDR_O(FL_ADDR_O), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE_N_O(FL_DQ_OE_N_O),
    .FL_CE_N_O(FL_CE_N_O), .FL_WE_N_O(FL_WE_N_O), .FL_OE_N_O(FL_OE_N_O), .FL_HW_RESET_N_O(FL_HW_RESET_N_O),
    .FL_BYTE_WIDTH_SELECT_N_O(FL_BYTE_WIDTH_SELECT_N_O), .FL_ACCEL_HV_O(FL_ACCEL_HV_O));

// [verif/tb_top.sv]
// self-checking bench for the flash bank command controller
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, v;
    logic [19:0] fa;
    logic [15:0] fdq, fdq_in, mdq;
    logic oe_dq_n, ce_n, we_n, oe_n, hw_n, byte_n, accel, rdy_n;
    logic [1:0] cfg = 2'b00;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    always #5 clk = ~clk;
    // the data wire: controller when it drives, flash otherwise
    assign fdq_in = oe_dq_n ? mdq : fdq;
    fbc_top i_dut (.CLK_I(clk), .ARST_N_I(arst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .FL_ADDR_O(fa), .FL_DQ_O(fdq), .FL_DQ_OE_N_O(oe_dq_n), .FL_DQ_I(fdq_in),
        .FL_CE_N_O(ce_n), .FL_WE_N_O(we_n), .FL_OE_N_O(oe_n), .FL_HW_RESET_N_O(hw_n),
        .FL_BYTE_WIDTH_SELECT_N_O(byte_n), .FL_ACCEL_HV_O(accel), .FL_READY_BUSY_N_I(rdy_n));
    fbc_flash_model i_flash (.ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .hw_reset_n_i(hw_n), .accel_i(accel),
        .addr_i(fa), .dq_i(fdq_in), .dq_o(mdq), .ready_busy_n_o(rdy_n));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    // one controller operation, polled until it reports done
    task automatic op(input logic [3:0] code, input logic [19:0] a, input logic [15:0] d);
        wreg(fbc_pkg::REG_ADDR, {12'h000, a});
        wreg(fbc_pkg::REG_WDATA, {16'h0000, d});
        wreg(fbc_pkg::REG_CTRL, {26'h0, cfg, code});
        for (int i = 0; i < 300; i++) begin
            rreg(fbc_pkg::REG_STAT);
            if (v[0] === 1'b0) break;
        end
        chk({27'h0, v[4], 2'h0, v[1:0]}, 32'h0, "status");
    endtask
    task automatic rdf(input logic [19:0] a, input logic [15:0] e, input string w);
        op(fbc_pkg::OP_READ, a, 16'h0000);
        rreg(fbc_pkg::REG_RDATA);
        chk(v, {16'h0000, e}, w);
    endtask
    task automatic t_reset();
        chk({hw_n, we_n, ce_n, oe_n}, 32'hF, "idle pins");
        rreg(fbc_pkg::REG_STAT);
        chk(v, 32'h0, "stat");
        wreg(fbc_pkg::REG_ADDR, 32'hFFF12345);
        wreg(4'hF, 32'h0);
        rreg(fbc_pkg::REG_ADDR);
        chk(v, 32'h00012345, "addr reg");
    endtask
    task automatic t_program();
        op(fbc_pkg::OP_PROGRAM, 20'h00123, 16'h1234);
        rdf(20'h00123, 16'h1234, "program");
        op(fbc_pkg::OP_PROGRAM, 20'h00123, 16'hFF00);
        rdf(20'h00123, 16'h1200, "clear only");
        op(fbc_pkg::OP_PROGRAM, 20'hFFFFF, 16'h0F0F);
        rdf(20'hFFFFF, 16'h0F0F, "top address");
    endtask
    task automatic t_autosel();
        op(fbc_pkg::OP_AUTOSEL, 20'h00000, 16'h0000);
        rdf(20'h00000, i_flash.MAKER_CODE, "maker");
        rdf(20'h00001, i_flash.DEV_CODE, "device");
        rdf(20'h00002, 16'h0001, "protect");
        op(fbc_pkg::OP_RESET, 20'h00000, 16'h0000);
        rdf(20'h00123, 16'h1200, "after reset");
    endtask
    task automatic t_bypass();
        op(fbc_pkg::OP_BYP_ENTER, 20'h00000, 16'h0000);
        rreg(fbc_pkg::REG_STAT);
        chk({31'h0, v[2]}, 32'h1, "bypass on");
        op(fbc_pkg::OP_BYP_PROG, 20'h00200, 16'h3C3C);
        op(fbc_pkg::OP_BYP_PROG, 20'h00201, 16'hA5A5);
        op(fbc_pkg::OP_BYP_EXIT, 20'h00000, 16'h0000);
        chk({31'h0, i_flash.byp}, 32'h0, "bypass left");
        rdf(20'h00200, 16'h3C3C, "bypass word 0");
        rdf(20'h00201, 16'hA5A5, "bypass word 1");
    endtask
    task automatic t_secured();
        op(fbc_pkg::OP_SEC_ENTER, 20'h00005, 16'h0000);
        rreg(fbc_pkg::REG_STAT);
        chk({31'h0, v[3]}, 32'h1, "secured on");
        rdf(20'h00005, i_flash.SEC_WORD, "secured data");
        op(fbc_pkg::OP_SEC_EXIT, 20'h00005, 16'h0000);
        rdf(20'h00005, 16'hFFFF, "secured exit");
        op(fbc_pkg::OP_SEC_ENTER, 20'h00005, 16'h0000);
        op(fbc_pkg::OP_HW_RESET, 20'h00000, 16'h0000);
        rdf(20'h00005, 16'hFFFF, "after hw reset");
    endtask
    task automatic t_pins();
        cfg = 2'b01;
        wreg(fbc_pkg::REG_CTRL, {26'h0, cfg, 4'h0});
        #1;
        chk({31'h0, accel}, 32'h1, "accel pin");
        op(fbc_pkg::OP_BYP_PROG, 20'h00300, 16'h00AA);
        cfg = 2'b10;
        rdf(20'h00300, 16'h00AA, "accel program");
        chk({31'h0, byte_n}, 32'h0, "byte pin");
        cfg = 2'b00;
        wreg(fbc_pkg::REG_CTRL, 32'h0);
        #1;
        chk({30'h0, byte_n, accel}, 32'h2, "word pins");
        chk(i_flash.perr, 32'h0, "sequences");
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // cycle ceiling against a hang
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_program();
        t_autosel();
        t_bypass();
        t_secured();
        t_pins();
        end_sim();
    end
endmodule
